// [core/swt_map.svh]
`ifndef SWT_MAP_SVH
`define SWT_MAP_SVH
// Contract
// (R1) Command refused and ignored while the line-busy flag is set.
// (R2) Triplet ends within three slots plus at most 1.09 us.
// (R3) Line activity starts at most 1.09 us after command acceptance.
// (R4) Accepted triplet points the read pointer at the master status register.
// (R5) Line-busy flag stays set for three slots during a triplet.
// (R6) First bit result at first sample; second bit and direction at second.
// (R7) Triplet uses speed, pullup, write-zero, write-one, recovery and resistor settings.
// (R8) Triplet parameter bit 7 picks the write slot when both reads are zero.
// (R9) Block receive code E1h reads 1 to 63 bytes into the scratchpad.
// (R10) Received bytes stored consecutively from scratchpad location zero.
// (R11) Block size from parameter bits 5:0; zero means one byte.
// (R12) Block receive ends within bytes times eight slots plus at most 1.09 us.
// (R13) Line-busy flag stays set for eight slots per received byte.
// (R14) Accepted block receive points the read pointer at the master status register.
// (R15) Block receive uses speed, pullup, write-one, recovery and resistor settings.
// (R16) Triplet code 78h makes two read slots then one write slot.
// (R17) Write slot: 01 gives zero, 10 and 11 give one, 00 uses bit 7.
// (R18) Host issues no triplet while earlier line activity continues.
// (R19) Line-busy flag clears after the final slot and its recovery.
`define SWT_OFF_CMD 9'h000
`define SWT_OFF_STATUS 9'h004
`define SWT_OFF_CONFIG 9'h008
`define SWT_OFF_TIM0 9'h00c
`define SWT_OFF_TIM1 9'h010
`define SWT_OFF_RDPTR 9'h014
`define SWT_SCR_BIT 8
`define SWT_CMD_TRIPLET 8'h78
`define SWT_CMD_BLOCK 8'he1
`define SWT_ST_BUSY 0
`define SWT_ST_REFUSED 1
`define SWT_ST_SBR 5
`define SWT_ST_TSB 6
`define SWT_ST_DIR 7
`define SWT_CFG_SPEED 0
`define SWT_CFG_APU 1
`define SWT_CFG_WPU 2
`define SWT_TRIP_V 7
`define SWT_BS_MSB 5
`define SWT_RST_CONFIG 3'h0
`define SWT_RST_W0L 16'h04b0
`define SWT_RST_W1L 16'h00a0
`define SWT_RST_REC 16'h0064
`define SWT_RST_MSR 16'h00f0
`define SWT_CLK_NS 50
`define SWT_START_MAX_NS 1090
`define SWT_START_MAX_CYC (`SWT_START_MAX_NS / `SWT_CLK_NS)
`define SWT_START_LAT_CYC 2
`define SWT_SLOT_STD_CYC 1300
`define SWT_SLOT_OD_CYC 200
`define SWT_APU_CYC 40
`endif

// [core/swt_pkg.sv]
package swt_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SLOT = 2'b01,
		ST_REC = 2'b11,
		ST_NEXT = 2'b10
	} swt_state_e;
	typedef enum logic [1:0] {
		SL_READ = 2'b00,
		SL_W0 = 2'b01,
		SL_W1 = 2'b10
	} swt_slot_e;
	typedef enum logic {
		MD_TRIPLET = 1'b0,
		MD_BLOCK = 1'b1
	} swt_mode_e;
endpackage : swt_pkg

// [core/swt_top.sv]
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "swt_map.svh"

module swt_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	generate
		if (D < 2 || (1 << AW) != D) begin : g_bad_depth
			$error("fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0] mem_q [0:D-1];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;

	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = cnt_q != D[AW:0];
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= push ? wp_q + 1'b1 : wp_q;
			rp_q <= pop ? rp_q + 1'b1 : rp_q;
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule : swt_fifo

////////////////////////////////////////////////////////////////////////////////

module swt_top import swt_pkg::*; #(
	parameter int SLOT_STD_CYC = `SWT_SLOT_STD_CYC,
	parameter int SLOT_OD_CYC = `SWT_SLOT_OD_CYC,
	parameter int APU_CYC = `SWT_APU_CYC,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Single-wire line, open drain
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	// Pullup control
	output logic strong_pullup_en,
	output logic weak_pullup_sel
);
	generate
		if (SLOT_STD_CYC < 2 || SLOT_STD_CYC > 65535 || SLOT_OD_CYC < 2 ||
			SLOT_OD_CYC > 65535 || APU_CYC < 1 || APU_CYC > 65535 ||
			`SWT_START_LAT_CYC > `SWT_START_MAX_CYC) begin : g_bad_param
			$error("slot or pullup cycle count out of range");
		end
	endgenerate

	localparam logic [15:0] SLOT_STD = 16'(SLOT_STD_CYC);
	localparam logic [15:0] SLOT_OD = 16'(SLOT_OD_CYC);
	localparam logic [16:0] APU_LEN = 17'(APU_CYC);

	////////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state on every access

	logic ack_q;
	logic [31:0] rdata_q;
	logic [2:0] config_q;
	logic [15:0] w0l_q;
	logic [15:0] w1l_q;
	logic [15:0] rec_q;
	logic [15:0] msr_q;
	logic [8:0] rdptr_q;
	logic refused_q;
	logic sbr_q;
	logic tsb_q;
	logic dir_q;

	wire req = avs_read | avs_write;
	wire wr_go = avs_write & ack_q;
	wire rd_load = avs_read & ~ack_q;
	wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire sel_scr = avs_address[`SWT_SCR_BIT];
	wire sel_cmd = avs_address == `SWT_OFF_CMD;
	wire sel_status = avs_address == `SWT_OFF_STATUS;
	wire sel_config = avs_address == `SWT_OFF_CONFIG;
	wire sel_tim0 = avs_address == `SWT_OFF_TIM0;
	wire sel_tim1 = avs_address == `SWT_OFF_TIM1;
	wire sel_rdptr = avs_address == `SWT_OFF_RDPTR;
	wire [31:0] tim0_w = ({w1l_q, w0l_q} & ~wmask) | (avs_writedata & wmask);
	wire [31:0] tim1_w = ({msr_q, rec_q} & ~wmask) | (avs_writedata & wmask);

	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Command acceptance

	swt_state_e state_q;
	swt_mode_e mode_q;
	wire busy = state_q != ST_IDLE;
	wire cmd_wr = wr_go & sel_cmd & (&avs_byteenable[1:0]);
	wire [7:0] cmd_code = avs_writedata[7:0];
	wire [7:0] cmd_param = avs_writedata[15:8];
	wire is_trip = cmd_code == `SWT_CMD_TRIPLET;
	wire is_blk = cmd_code == `SWT_CMD_BLOCK;
	wire accept = cmd_wr & ~busy & (is_trip | is_blk); // (R1) (R18)
	wire refuse = cmd_wr & ~accept; // (R1)
	wire [5:0] bs_field = cmd_param[`SWT_BS_MSB:0]; // (R11)
	wire [5:0] bytes_m1 = (bs_field == 6'h00) ? 6'h00 : bs_field - 6'h01; // (R11)

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			config_q <= `SWT_RST_CONFIG;
			{w1l_q, w0l_q} <= {`SWT_RST_W1L, `SWT_RST_W0L};
			{msr_q, rec_q} <= {`SWT_RST_MSR, `SWT_RST_REC};
			rdptr_q <= `SWT_OFF_STATUS;
			refused_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
			if (wr_go & sel_config & avs_byteenable[0]) begin
				config_q <= avs_writedata[2:0];
			end
			if (wr_go & sel_tim0) begin
				{w1l_q, w0l_q} <= tim0_w;
			end
			if (wr_go & sel_tim1) begin
				{msr_q, rec_q} <= tim1_w;
			end
			if (accept) begin
				rdptr_q <= `SWT_OFF_STATUS; // (R4) (R14)
			end else if (wr_go & sel_rdptr) begin
				rdptr_q <= avs_writedata[8:0];
			end
			refused_q <= refuse ? 1'b1 : (accept ? 1'b0 : refused_q); // (R1)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Slot engine

	logic [15:0] cnt_q;
	logic [2:0] slot_q;
	logic [5:0] left_q;
	logic [7:0] shift_q;
	logic b1_q;
	logic v_q;
	logic oe_q;
	logic spu_q;
	swt_slot_e kind;

	// (R16) (R17)
	always_comb begin
		kind = SL_READ;
		if (mode_q == MD_TRIPLET && slot_q == 3'd2) begin
			kind = dir_q ? SL_W1 : SL_W0;
		end
	end

	// Timing registers are sampled live so a new setting applies at once, even within the slot in progress
	wire [15:0] slot_len = config_q[`SWT_CFG_SPEED] ? SLOT_OD : SLOT_STD; // (R7) (R15)
	wire [15:0] low_len = (kind == SL_W0) ? w0l_q : w1l_q; // (R7) (R15)
	wire slot_end = cnt_q == slot_len - 16'h0001;
	// Decision cycle is the last recovery cycle, so slot plus recovery stays exact
	wire rec_done = ({1'b0, cnt_q} + 17'h00002) >= {1'b0, rec_q}; // (R7) (R15)
	wire sample = (state_q == ST_SLOT) & (kind == SL_READ) & (cnt_q == msr_q);
	wire blk_byte = (mode_q == MD_BLOCK) & (slot_q == 3'd7);
	wire last = (mode_q == MD_TRIPLET) ? (slot_q == 3'd2) : (blk_byte & (left_q == 6'h00));
	wire fifo_in_ready;
	wire push = (state_q == ST_NEXT) & blk_byte;
	wire stall = push & ~fifo_in_ready;
	wire drive_low = (state_q == ST_SLOT) & (cnt_q < low_len);
	wire in_apu = ({1'b0, cnt_q} >= {1'b0, low_len}) &
		({1'b0, cnt_q} < {1'b0, low_len} + APU_LEN);
	wire spu_d = config_q[`SWT_CFG_APU] & (state_q == ST_SLOT) & in_apu; // (R7) (R15)

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			mode_q <= MD_TRIPLET;
			cnt_q <= '0;
			slot_q <= '0;
			left_q <= '0;
			v_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (accept) begin
						state_q <= ST_SLOT; // (R3)
						mode_q <= is_blk ? MD_BLOCK : MD_TRIPLET; // (R9) (R16)
						cnt_q <= '0;
						slot_q <= '0;
						left_q <= bytes_m1; // (R11)
						v_q <= cmd_param[`SWT_TRIP_V]; // (R8)
					end
				end
				ST_SLOT: begin
					cnt_q <= slot_end ? 16'h0000 : cnt_q + 16'h0001;
					if (slot_end) begin
						state_q <= ST_REC;
					end
				end
				ST_REC: begin
					cnt_q <= cnt_q + 16'h0001;
					if (rec_done) begin
						state_q <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					// A full FIFO holds the line idle between bytes
					cnt_q <= '0;
					if (!stall) begin
						state_q <= last ? ST_IDLE : ST_SLOT; // (R2) (R5) (R12) (R13) (R19)
						slot_q <= slot_q + 3'd1;
						left_q <= blk_byte ? left_q - 6'h01 : left_q; // (R13)
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sbr_q <= 1'b0;
			tsb_q <= 1'b0;
			dir_q <= 1'b0;
			b1_q <= 1'b0;
			shift_q <= '0;
			oe_q <= 1'b0;
			spu_q <= 1'b0;
		end else begin
			oe_q <= drive_low;
			spu_q <= spu_d;
			if (sample && mode_q == MD_TRIPLET && slot_q == 3'd0) begin
				sbr_q <= line_in; // (R6)
				b1_q <= line_in;
			end
			if (sample && mode_q == MD_TRIPLET && slot_q == 3'd1) begin
				tsb_q <= line_in; // (R6)
				dir_q <= b1_q | (~line_in & v_q); // (R6) (R8) (R17)
			end
			if (sample && mode_q == MD_BLOCK) begin
				shift_q <= {line_in, shift_q[7:1]}; // (R9)
			end
		end
	end

	assign line_out = 1'b0;
	assign line_oe = oe_q;
	assign strong_pullup_en = spu_q;
	assign weak_pullup_sel = config_q[`SWT_CFG_WPU]; // (R7) (R15)

	////////////////////////////////////////////////////////////////////////////
	// Receive FIFO and input scratchpad

	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	// Drain yields to a bus read so the scratchpad needs one port only
	wire fifo_out_ready = ~(rd_load & sel_scr);
	logic [5:0] wp_q;
	logic [7:0] scr_q [0:63];

	swt_fifo #(
		.W(8),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(shift_q),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	wire drain = fifo_out_valid & fifo_out_ready;

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q <= '0;
		end else if (accept && is_blk) begin
			wp_q <= '0; // (R10)
		end else if (drain) begin
			wp_q <= wp_q + 6'h01; // (R10)
		end
	end

	always_ff @(posedge clk) begin
		if (drain) begin
			scr_q[wp_q] <= fifo_out_data; // (R9) (R10)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data

	logic [31:0] status_w;
	logic [31:0] rd_mux;

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`SWT_ST_BUSY] = busy; // (R5) (R13) (R19)
		status_w[`SWT_ST_REFUSED] = refused_q;
		status_w[`SWT_ST_SBR] = sbr_q;
		status_w[`SWT_ST_TSB] = tsb_q;
		status_w[`SWT_ST_DIR] = dir_q;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_scr) begin
			rd_mux = {24'h00_0000, scr_q[avs_address[7:2]]};
		end else if (sel_status) begin
			rd_mux = status_w;
		end else if (sel_config) begin
			rd_mux = {29'h0000_0000, config_q};
		end else if (sel_tim0) begin
			rd_mux = {w1l_q, w0l_q};
		end else if (sel_tim1) begin
			rd_mux = {msr_q, rec_q};
		end else if (sel_rdptr) begin
			rd_mux = {23'h00_0000, rdptr_q};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_load) begin
			rdata_q <= rd_mux;
		end
	end
endmodule : swt_top

// [tb/swt_props.sv]
`timescale 1ns/1ps
`include "swt_map.svh"

module swt_props #(
	parameter int APU_CYC = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Line and pullups
	input wire logic line_in,
	input wire logic line_out,
	input wire logic line_oe,
	input wire logic strong_pullup_en,
	input wire logic weak_pullup_sel
);
	localparam int START_MAX = `SWT_START_MAX_CYC;
	logic done_w, cmd_w, idle_w, idle_q, idle_d;
	logic [15:0] apu_q, apu_d;
	assign done_w = !avs_waitrequest && (avs_read || avs_write);
	assign cmd_w = done_w && avs_write && avs_address == `SWT_OFF_CMD
		&& (avs_writedata[7:0] == `SWT_CMD_TRIPLET || avs_writedata[7:0] == `SWT_CMD_BLOCK);
	// Idle known only from a status read, so refused writes never look like starts
	assign idle_w = done_w && avs_read && avs_address == `SWT_OFF_STATUS && !avs_readdata[0];
	assign idle_d = cmd_w ? 1'b0 : (idle_w ? 1'b1 : idle_q);
	assign apu_d = strong_pullup_en ? apu_q + 16'h1 : 16'h0;
	always_ff @(posedge clk) begin
		idle_q <= rst ? 1'b0 : idle_d;
		apu_q <= rst ? 16'h0 : apu_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait state");
	a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state too long");
	a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait while idle");
	a_line_start: assert property (cmd_w && idle_q |-> ##[1:START_MAX] line_oe)
		else $error("line start late");
	a_oe_no_spu: assert property (line_oe |-> !strong_pullup_en)
		else $error("strong pullup while low");
	a_drive_low: assert property (line_oe |-> !line_out)
		else $error("line driven high");
	a_apu_len: assert property ($fell(strong_pullup_en) |-> apu_q == APU_CYC)
		else $error("strong pullup length");
	a_wpu_follows: assert property (done_w && avs_write && avs_address == `SWT_OFF_CONFIG
		&& avs_byteenable[0] |=> weak_pullup_sel == $past(avs_writedata[`SWT_CFG_WPU]))
		else $error("weak pullup select");
	a_rdata_stable: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	a_unmap_zero: assert property (done_w && avs_read && avs_address >= 9'h018
		&& avs_address < 9'h100 |-> avs_readdata == 32'h0)
		else $error("unmapped read");
endmodule : swt_props

bind swt_top swt_props #(.APU_CYC(APU_CYC)) swt_props_inst (.clk(clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .line_in(line_in), .line_out(line_out),
	.line_oe(line_oe), .strong_pullup_en(strong_pullup_en), .weak_pullup_sel(weak_pullup_sel));

// [tb/swt_line_slave.sv]
`timescale 1ns/1ps

module swt_line_slave #(
	parameter int HOLD = 12
) (
	// Clock
	input wire logic clk,
	// Line
	input wire logic line_oe,
	output logic slave_low,
	// Bench control
	input wire logic restart,
	input wire logic [255:0] pattern
);
	logic oe_q;
	logic [7:0] idx_q;
	int hold_q = 0;
	// A zero bit stretches the low past the sample point; release lets the pullup win
	always_ff @(posedge clk) begin
		oe_q <= line_oe;
		if (restart) begin
			idx_q <= 8'h0;
		end else if (line_oe && !oe_q) begin
			idx_q <= idx_q + 8'h1;
		end
		if (line_oe && !oe_q && !pattern[idx_q]) begin
			hold_q <= HOLD;
		end else if (hold_q > 0) begin
			hold_q <= hold_q - 1;
		end
	end
	assign slave_low = hold_q > 0;
endmodule : swt_line_slave

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "swt_map.svh"

module tb_top;
	logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, restart = 1'b0;
	logic [8:0] avs_address = 9'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hf;
	logic avs_waitrequest, line_in, line_out, line_oe, spu, wps, slave_low, dir;
	logic [255:0] pattern = 256'h0, pat;
	logic [2:0] cfg;
	logic [64:0] exp_q[$];
	logic [64:0] e;
	int errors = 0, compares = 0, cyc = 0, npulse = 0, len = 0, last_len = 0;
	int seed = 3451, t0, n0, n;
	always #25 clk = ~clk;
	assign line_in = ~(line_oe | slave_low);
	swt_top #(.SLOT_STD_CYC(40), .SLOT_OD_CYC(20), .APU_CYC(4)) swt_top_inst (.clk(clk),
		.rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .strong_pullup_en(spu), .weak_pullup_sel(wps));
	swt_line_slave swt_line_slave_inst (.clk(clk), .line_oe(line_oe), .slave_low(slave_low),
		.restart(restart), .pattern(pattern));
	task check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : check
	task final_report;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	task bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk iff !avs_waitrequest);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task rd(input logic [8:0] a, input logic [31:0] m, input logic [31:0] w, input logic c);
		exp_q.push_back({c, m, w});
		bus(1'b0, a, 32'h0);
	endtask : rd
	task cmd(input logic [31:0] d);
		bus(1'b1, `SWT_OFF_RDPTR, 32'h8);
		restart <= 1'b1;
		n0 = npulse;
		bus(1'b1, `SWT_OFF_CMD, d);
		restart <= 1'b0;
		t0 = cyc;
	endtask : cmd
	// Polls until busy drops, then checks span and slot count
	task span(input int slots);
		int d;
		int sl;
		q = 32'h1;
		while (q[0]) rd(`SWT_OFF_STATUS, 32'h0, 32'h0, 1'b0);
		d = cyc - t0;
		sl = cfg[0] ? 20 : 40;
		check({31'h0, d >= slots * (sl + 3) && d <= slots * (sl + 3) + `SWT_START_MAX_CYC}, 32'h1);
		check(32'(npulse - n0), 32'(slots));
	endtask : span
	always @(posedge clk) begin
		cyc++;
		if (line_oe) begin
			len++;
		end else if (len > 0) begin
			last_len = len;
			len = 0;
			npulse++;
		end
		if (avs_read && !avs_waitrequest) begin
			e = exp_q.pop_front();
			if (e[64]) check(avs_readdata & e[63:32], e[31:0]);
		end
		if (cyc == 30000) begin
			errors++;
			final_report;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(`SWT_OFF_CONFIG, 32'h7, 32'h0, 1'b1);
		rd(`SWT_OFF_TIM0, 32'hffffffff, {`SWT_RST_W1L, `SWT_RST_W0L}, 1'b1);
		rd(`SWT_OFF_TIM1, 32'hffffffff, {`SWT_RST_MSR, `SWT_RST_REC}, 1'b1);
		rd(`SWT_OFF_RDPTR, 32'h1ff, 32'h4, 1'b1);
		rd(9'h018, 32'hffffffff, 32'h0, 1'b1);
		rd(`SWT_OFF_STATUS, 32'h3, 32'h0, 1'b1);
		bus(1'b1, `SWT_OFF_TIM0, {16'h4, 16'h10});
		bus(1'b1, `SWT_OFF_TIM1, {16'h8, 16'h3});
		cfg = 3'($random(seed)) | 3'h2;
		bus(1'b1, `SWT_OFF_CONFIG, {29'h0, cfg});
		rd(`SWT_OFF_CONFIG, 32'h7, {29'h0, cfg}, 1'b1);
		for (int i = 0; i < 8; i++) begin
			pattern <= {253'h0, 1'b1, i[1], i[0]};
			dir = i[0] | (~i[1] & i[2]);
			cmd({16'h0, i[2], 7'($random(seed)), `SWT_CMD_TRIPLET});
			if (i == 0) begin
				bus(1'b1, `SWT_OFF_CMD, {16'h0, 8'h0, `SWT_CMD_BLOCK});
				rd(`SWT_OFF_STATUS, 32'h3, 32'h3, 1'b1);
			end
			rd(`SWT_OFF_RDPTR, 32'h1ff, 32'h4, 1'b1);
			span(3);
			check(32'(last_len), dir ? 32'h4 : 32'h10);
			rd(`SWT_OFF_STATUS, 32'he1, {24'h0, dir, i[1], i[0], 5'h0}, 1'b1);
		end
		for (int k = 0; k < 2; k++) begin
			n = k ? 17 : 1;
			for (int j = 0; j < 8; j++) pat[32 * j +: 32] = $random(seed);
			pattern <= pat;
			cmd({16'h0, 2'($random(seed)), k ? 6'h11 : 6'h0, `SWT_CMD_BLOCK});
			rd(`SWT_OFF_RDPTR, 32'h1ff, 32'h4, 1'b1);
			span(8 * n);
			check(32'(last_len), 32'h4);
			for (int j = 0; j < n; j++) rd(9'h100 + 9'(4 * j), 32'hff, {24'h0, pat[8 * j +: 8]}, 1'b1);
		end
		final_report;
	end
endmodule : tb_top
